// ### logic/bod_pkg.sv
// constants, register map and state types for the byte-op decoder
// Operation
// - access bit 0 uses fixed access region; 1 uses bank_select_reg bank.
// - destination bit 0 writes working_accumulator; 1 writes the file register.
// - file field is 8-bit address 00h-FFh, or 2-bit indirect_pointer select.
// - full_range_move source and destination are 12-bit addresses 000h-FFFh.
// - 3-bit bit index picks bit 0 to 7 of an 8-bit file register.
// - call/return fast bit set moves shadow copies; clear moves nothing.
// - table ops apply none, post-inc, post-dec or pre-inc to 21-bit pointer.
// - don't-care encoding bits never change decoding.
// - five flags carry, half carry, zero, overflow, negative; per-op subset.
// - branch and rcall offsets are two's complement; call and goto use direct address.
// - literals extracted at 8, 12 or 20 bits depending on instruction.
// - add_acc_to_file and add_acc_carry_to_file take 1 cycle, set all five flags.
// - logic_and_file, logic_or_file, invert_file: 1 cycle, zero and negative only.
// - compare skips leave flags, skip when true, 1 cycle or 2/3 when skipping.
// - skip-if-zero forms keep flags; plain minus/plus one set all five flags.
// - skip-if-nonzero forms skip on nonzero result and keep flags.
// - full_range_move is two words 1100/1111, two cycles, no flag change.
// - multiply_acc_file takes 1 cycle and changes no flag.
// - rotate via carry passes carry in, updates carry, zero and negative.
// - rotate_left_plain rotates in place, 1 cycle, zero and negative only.
// - program counter change costs two cycles, true test two or three (over a two-word instruction), extra is no-op.
// - lone second word of a two-word instruction executes as no-operation.
`default_nettype none
package bod_pkg;
  localparam int AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] REG_INSTR   = 8'h00;
  localparam logic [7:0] REG_FILE_IN = 8'h04;
  localparam logic [7:0] REG_ACC     = 8'h08;
  localparam logic [7:0] REG_FLAGS   = 8'h0C;
  localparam logic [7:0] REG_BANK    = 8'h10;
  localparam logic [7:0] REG_PROGRAM_TABLE_POINTER  = 8'h14;
  localparam logic [7:0] REG_CTRL    = 8'h18;
  localparam logic [7:0] REG_RESULT  = 8'h1C;
  localparam logic [7:0] REG_ADDR    = 8'h20;
  localparam logic [7:0] REG_MOVE    = 8'h24;
  localparam logic [7:0] REG_LIT     = 8'h28;
  localparam logic [7:0] REG_DISP    = 8'h2C;
  localparam logic [7:0] REG_PROD    = 8'h30;
  localparam logic [7:0] REG_SHADOW  = 8'h34;
  localparam logic [7:0] REG_TBLUSE  = 8'h38;
  // control bits
  localparam int CTRL_GO  = 0;
  localparam int CTRL_NX2 = 1;
  // flag positions
  localparam int FL_C  = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z  = 2;
  localparam int FL_OV = 3;
  localparam int FL_N  = 4;
  // access region split and upper and lower access banks
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;
  localparam logic [3:0] ACCESS_LOW   = 4'h0;
  // six-bit byte-op opcodes
  localparam logic [5:0] OP_ADD   = 6'b001001;
  localparam logic [5:0] OP_ADDC  = 6'b001000;
  localparam logic [5:0] OP_AND   = 6'b000101;
  localparam logic [5:0] OP_OR    = 6'b000100;
  localparam logic [5:0] OP_INV   = 6'b000111;
  localparam logic [5:0] OP_DEC   = 6'b000001;
  localparam logic [5:0] OP_INC   = 6'b001010;
  localparam logic [5:0] OP_DECSZ = 6'b001011;
  localparam logic [5:0] OP_INCSZ = 6'b001111;
  localparam logic [5:0] OP_DECNZ = 6'b010011;
  localparam logic [5:0] OP_INCNZ = 6'b010010;
  localparam logic [5:0] OP_RLC   = 6'b001101;
  localparam logic [5:0] OP_RRC   = 6'b001100;
  localparam logic [5:0] OP_RLN   = 6'b010001;
  // seven-bit opcodes
  localparam logic [6:0] OP_CPEQ = 7'b0110001;
  localparam logic [6:0] OP_CPGT = 7'b0110010;
  localparam logic [6:0] OP_CPLT = 7'b0110000;
  localparam logic [6:0] OP_MUL  = 7'b0000001;
  localparam logic [6:0] OP_CALL = 7'b1110110;
  // other prefixes
  localparam logic [3:0]  OP4_MOVE   = 4'hC;
  localparam logic [3:0]  OP4_SECOND = 4'hF;
  localparam logic [4:0]  OP5_BRA    = 5'b11010;
  localparam logic [4:0]  OP5_RCALL  = 5'b11011;
  localparam logic [4:0]  OP5_LIT8   = 5'b00001;
  localparam logic [7:0]  OP8_GOTO   = 8'hEF;
  localparam logic [9:0]  OP10_LPTR  = 10'b1110111000;
  localparam logic [13:0] OP14_TBLRD = 14'b00000000000010;
  localparam logic [13:0] OP14_TBLWR = 14'b00000000000011;
  localparam logic [14:0] OP15_RETI  = 15'h0008;
  localparam logic [14:0] OP15_RET   = 15'h0009;
  // table pointer modes
  localparam logic [1:0] TM_NONE = 2'b00;
  localparam logic [1:0] TM_PINC = 2'b01;
  localparam logic [1:0] TM_PDEC = 2'b10;
  localparam logic [1:0] TM_PRE  = 2'b11;
  // literal width codes
  localparam logic [1:0] LW_8  = 2'd1;
  localparam logic [1:0] LW_12 = 2'd2;
  localparam logic [1:0] LW_20 = 2'd3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {PEND_NONE, PEND_MOVE, PEND_LONG, PEND_PTR}
    bod_pend_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       instr;
    logic [7:0]        file_in;
    logic [7:0]        acc;
    logic [4:0]        flags;
    logic [3:0]        bank;
    logic [20:0]       program_table_pointer;
    logic [20:0]       tbluse;
    logic [7:0]        sh_acc;
    logic [4:0]        sh_flags;
    logic [3:0]        sh_bank;
    bod_pend_t         pend;
    logic [11:0]       move_src;
    logic [11:0]       move_dst;
    logic [7:0]        result;
    logic              dest_file;
    logic              skip;
    logic [1:0]        cycles;
    logic              handled;
    logic [11:0]       eff_addr;
    logic [1:0]        ptr_sel;
    logic [7:0]        bit_mask;
    logic [19:0]       lit;
    logic [1:0]        lit_w;
    logic [20:0]       disp;
    logic              disp_rel;
    logic [15:0]       prod;
  } bod_state_t;
endpackage
`default_nettype wire

// ### logic/bod_decoder.sv
// byte-oriented instruction decoder and executor behind an AXI4-Lite slave
`default_nettype none
module bod_decoder (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [bod_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [bod_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import bod_pkg::*;

  bod_state_t s_reg;
  bod_state_t s_next;

  // merge a write into an old word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  // add with carry in, returns {ov, dc, c, sum}
  function automatic logic [10:0] add8(input logic [7:0] x,
                                       input logic [7:0] y,
                                       input logic       cin);
    logic [8:0] sm;
    logic [4:0] hf;
    logic       ov;
    sm = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    hf = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    ov = (x[7] == y[7]) && (sm[7] != x[7]);
    return {ov, hf[4], sm[8], sm[7:0]};
  endfunction

  // register readback
  function automatic logic [31:0] rd_mux(input bod_state_t st,
                                         input logic [AXI_AW-1:0] ad);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ad)
      REG_INSTR:   v = {16'h0000, st.instr};
      REG_FILE_IN: v = {24'h000000, st.file_in};
      REG_ACC:     v = {24'h000000, st.acc};
      REG_FLAGS:   v = {27'h0000000, st.flags};
      REG_BANK:    v = {28'h0000000, st.bank};
      REG_PROGRAM_TABLE_POINTER:  v = {11'h000, st.program_table_pointer};
      REG_CTRL:    v = 32'h0000_0000;
      REG_RESULT:  v = {16'h0000, 1'b0, st.pend, st.handled,
                        st.cycles, st.skip, st.dest_file, st.result};
      REG_ADDR:    v = {10'h000, st.bit_mask, st.ptr_sel, st.eff_addr};
      REG_MOVE:    v = {8'h00, st.move_dst, st.move_src};
      REG_LIT:     v = {10'h000, st.lit_w, st.lit};
      REG_DISP:    v = {st.disp_rel, 10'h000, st.disp};
      REG_PROD:    v = {16'h0000, st.prod};
      REG_SHADOW:  v = {15'h0000, st.sh_bank, st.sh_flags, st.sh_acc};
      REG_TBLUSE:  v = {11'h000, st.tbluse};
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] ad);
    return (ad[1:0] == 2'b00) && (ad <= REG_TBLUSE);
  endfunction

  logic [15:0]  ins;
  logic [5:0]   op6;
  logic [6:0]   op7;
  logic         dbit;
  logic         abit;
  logic [7:0]   fv;
  logic [7:0]   wv;
  logic [10:0]  ar;
  logic [7:0]   res;
  logic [4:0]   fl;
  logic         sk;
  logic         wr_res;
  logic         do_wr;
  logic         go;
  logic         nx2;
  logic [31:0]  wword;
  logic [AXI_AW-1:0] wad;

  // next-state logic: bus slave, register writes and instruction execution
  always_comb begin
    s_next = s_reg;
    ins    = s_reg.instr;
    op6    = ins[15:10];
    op7    = ins[15:9];
    dbit   = ins[9];
    abit   = ins[8];
    fv     = s_reg.file_in;
    wv     = s_reg.acc;
    ar     = 11'h000;
    res    = 8'h00;
    fl     = s_reg.flags;
    sk     = 1'b0;
    wr_res = 1'b0;
    wad    = s_reg.aw_addr;
    wword  = merge(rd_mux(s_reg, wad), s_reg.w_data, s_reg.w_strb);
    go     = 1'b0;
    nx2    = 1'b0;

    // address and data channels are taken independently
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    do_wr = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

    // register write, one cycle after both halves are held
    if (do_wr) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = mapped(wad) ? RESP_OKAY : RESP_SLVERR;
      unique case (wad)
        REG_INSTR:   s_next.instr   = wword[15:0];
        REG_FILE_IN: s_next.file_in = wword[7:0];
        REG_ACC:     s_next.acc     = wword[7:0];
        REG_FLAGS:   s_next.flags   = wword[4:0];
        REG_BANK:    s_next.bank    = wword[3:0];
        REG_PROGRAM_TABLE_POINTER:  s_next.program_table_pointer  = wword[20:0];
        REG_CTRL: begin
          go  = s_reg.w_strb[0] && s_reg.w_data[CTRL_GO];
          nx2 = s_reg.w_data[CTRL_NX2];
        end
        default: ;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // execute the held instruction word
    if (go) begin
      s_next.skip      = 1'b0;
      s_next.cycles    = 2'd1;
      s_next.handled   = 1'b1;
      s_next.dest_file = 1'b0;
      s_next.disp_rel  = 1'b0;
      s_next.ptr_sel = ins[1:0];
      if (!abit) begin
        s_next.eff_addr = {(ins[7:0] < ACCESS_SPLIT) ? ACCESS_LOW
                                                    : ACCESS_HIGH, ins[7:0]};
      end else begin
        s_next.eff_addr = {s_reg.bank, ins[7:0]};
      end
      // bit index one-hot within the file byte
      s_next.bit_mask = 8'h01 << ins[11:9];
      // default 8-bit literal from the low byte
      s_next.lit   = {12'h000, ins[7:0]};
      s_next.lit_w = LW_8;

      if (s_reg.pend != PEND_NONE) begin
        // second word consumed by the first word's fetch
        s_next.pend   = PEND_NONE;
        s_next.cycles = 2'd2;
        unique case (s_reg.pend)
          // 12-bit destination of the full-range move
          PEND_MOVE: s_next.move_dst = ins[11:0];
          PEND_LONG: begin
            s_next.lit   = {ins[11:0], s_reg.lit[7:0]};
            s_next.lit_w = LW_20;
            s_next.disp  = {1'b0, ins[11:0], s_reg.lit[7:0]};
          end
          PEND_PTR: begin
            s_next.lit   = {8'h00, s_reg.lit[3:0], ins[7:0]};
            s_next.lit_w = LW_12;
            s_next.ptr_sel = s_reg.ptr_sel;
          end
          default: ;
        endcase
      end else if (ins[15:12] == OP4_SECOND) begin
        // lone second word is a no-operation
        s_next.handled = 1'b1;
      end else if (ins[15:12] == OP4_MOVE) begin
        // first word holds the 12-bit source
        s_next.move_src = ins[11:0];
        s_next.pend     = PEND_MOVE;
        s_next.cycles   = 2'd2;
      end else if (ins[15:11] == OP5_BRA || ins[15:11] == OP5_RCALL) begin
        s_next.disp     = {{10{ins[10]}}, ins[10:0]};
        s_next.disp_rel = 1'b1;
        // program counter change takes two cycles
        s_next.cycles   = 2'd2;
      end else if (op7 == OP_CALL || ins[15:8] == OP8_GOTO) begin
        // direct address, low byte now, high part next word
        s_next.lit  = {12'h000, ins[7:0]};
        s_next.pend = PEND_LONG;
        s_next.cycles = 2'd2;
        if (op7 == OP_CALL && ins[8]) begin
          s_next.sh_acc   = s_reg.acc;
          s_next.sh_flags = s_reg.flags;
          s_next.sh_bank  = s_reg.bank;
        end
      end else if (ins[15:6] == OP10_LPTR) begin
        s_next.ptr_sel = ins[5:4];
        s_next.lit     = {16'h0000, ins[3:0]};
        s_next.pend    = PEND_PTR;
        s_next.cycles  = 2'd2;
      end else if (ins[15:1] == OP15_RET || ins[15:1] == OP15_RETI) begin
        s_next.cycles = 2'd2;
        if (ins[0]) begin
          s_next.acc   = s_reg.sh_acc;
          s_next.flags = s_reg.sh_flags;
          s_next.bank  = s_reg.sh_bank;
        end
      end else if (ins[15:2] == OP14_TBLRD || ins[15:2] == OP14_TBLWR) begin
        s_next.tbluse = (ins[1:0] == TM_PRE) ? s_reg.program_table_pointer + 21'd1
                                             : s_reg.program_table_pointer;
        unique case (ins[1:0])
          TM_NONE: s_next.program_table_pointer = s_reg.program_table_pointer;
          TM_PINC: s_next.program_table_pointer = s_reg.program_table_pointer + 21'd1;
          TM_PDEC: s_next.program_table_pointer = s_reg.program_table_pointer - 21'd1;
          TM_PRE:  s_next.program_table_pointer = s_reg.program_table_pointer + 21'd1;
        endcase
        s_next.cycles = 2'd2;
      end else if (ins[15:11] == OP5_LIT8) begin
        s_next.lit   = {12'h000, ins[7:0]};
        s_next.lit_w = LW_8;
      end else if (op7 == OP_CPEQ || op7 == OP_CPGT || op7 == OP_CPLT) begin
        unique case (op7)
          OP_CPEQ: sk = (fv == wv);
          OP_CPGT: sk = (fv > wv);
          default: sk = (fv < wv);
        endcase
      end else if (op7 == OP_MUL) begin
        s_next.prod = {8'h00, wv} * {8'h00, fv};
      end else begin
        wr_res = 1'b1;
        unique case (op6)
          OP_ADD, OP_ADDC: begin
            ar = add8(fv, wv, (op6 == OP_ADDC) && s_reg.flags[FL_C]);
            res = ar[7:0];
            fl  = {res[7], ar[10], (res == 8'h00), ar[9], ar[8]};
          end
          // logic ops set zero and negative only
          OP_AND, OP_OR, OP_INV: begin
            if (op6 == OP_AND) begin
              res = fv & wv;
            end else if (op6 == OP_OR) begin
              res = fv | wv;
            end else begin
              res = ~fv;
            end
            fl[FL_Z] = (res == 8'h00);
            fl[FL_N] = res[7];
          end
          // plain minus/plus one set all five flags
          OP_DEC, OP_INC: begin
            ar = (op6 == OP_DEC) ? add8(fv, 8'hFF, 1'b0)
                                 : add8(fv, 8'h00, 1'b1);
            res = ar[7:0];
            fl  = {res[7], ar[10], (res == 8'h00), ar[9], ar[8]};
          end
          // skip when result is zero, flags kept
          OP_DECSZ, OP_INCSZ: begin
            res = (op6 == OP_DECSZ) ? fv - 8'h01 : fv + 8'h01;
            sk  = (res == 8'h00);
          end
          // skip when result is nonzero, flags kept
          OP_DECNZ, OP_INCNZ: begin
            res = (op6 == OP_DECNZ) ? fv - 8'h01 : fv + 8'h01;
            sk  = (res != 8'h00);
          end
          OP_RLC, OP_RRC: begin
            if (op6 == OP_RLC) begin
              res      = {fv[6:0], s_reg.flags[FL_C]};
              fl[FL_C] = fv[7];
            end else begin
              res      = {s_reg.flags[FL_C], fv[7:1]};
              fl[FL_C] = fv[0];
            end
            fl[FL_Z] = (res == 8'h00);
            fl[FL_N] = res[7];
          end
          // rotate within the byte, carry untouched
          OP_RLN: begin
            res      = {fv[6:0], fv[7]};
            fl[FL_Z] = (res == 8'h00);
            fl[FL_N] = res[7];
          end
          default: begin
            // unknown word, nothing written and marked unhandled
            wr_res           = 1'b0;
            s_next.handled   = 1'b0;
          end
        endcase
      end

      // only the subset chosen above reaches the flags
      if (wr_res) begin
        s_next.flags  = fl;
        s_next.result = res;
        s_next.dest_file = dbit;
        if (!dbit) begin
          s_next.acc = res;
        end
      end
      // skip costs two cycles, three over a two-word instruction
      // true test adds a no-operation cycle
      if (sk) begin
        s_next.skip   = 1'b1;
        s_next.cycles = nx2 ? 2'd3 : 2'd2;
      end
    end

    // read channel, data one cycle after the address
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_mux(s_reg, s_axi_araddr);
      s_next.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    // readies as registered values
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
endmodule
`default_nettype wire

// ### tb/bod_decoder_props.sv
// bus and register read checks for the byte-op decoder
`default_nettype none
module bod_decoder_props (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [bod_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp
);
  import bod_pkg::*;
  logic [7:0] ra_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // remember the address of the read under way
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ra_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ra_reg <= s_axi_araddr;
    end
  end
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_b_late;
  endproperty
  a_b_lat:
    assert property (p_b_lat) else $error("write answer out of time");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat:
    assert property (p_r_lat) else $error("read answer out of time");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block:
    assert property (p_ar_block) else $error("read taken while answering");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block:
    assert property (p_aw_block) else $error("write taken while answering");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done:
    assert property (p_b_done) else $error("write answer not withdrawn");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done:
    assert property (p_r_done) else $error("read answer not withdrawn");
  property p_unmap;
    s_axi_rvalid && (ra_reg > 8'h38 || ra_reg[1:0] != 2'h0)
      |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmap:
    assert property (p_unmap) else $error("unmapped read not refused");
  property p_flags;
    s_axi_rvalid && ra_reg == REG_FLAGS |-> s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_flags:
    assert property (p_flags) else $error("flag word has extra bits");
endmodule
`default_nettype wire

// ### tb/bod_decoder_test.sv
// self-checking bench for the byte-op decoder
`default_nettype none
module bod_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bod_pkg::*;
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0]  f;
    logic [7:0]  a;
    logic [4:0]  fl;
    logic [7:0]  res;
    logic [4:0]  efl;
    logic [1:0]  sc;
  } bod_row_t;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [AXI_AW-1:0] s_axi_awaddr = '0;
  logic [AXI_AW-1:0] s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic [31:0]       s_axi_rdata, rv;
  int                num_errors = 0;
  int                checks_done = 0;
  // sc: skip bit then check-result bit
  bod_row_t rows [18] = '{
    '{16'h2610, 8'h01, 8'h7F, 5'h00, 8'h80, 5'h1A, 2'b01},
    '{16'h2210, 8'h00, 8'hFF, 5'h01, 8'h00, 5'h07, 2'b01},
    '{16'h1610, 8'h8F, 8'hF0, 5'h0B, 8'h80, 5'h1B, 2'b01},
    '{16'h1210, 8'h00, 8'h00, 5'h1B, 8'h00, 5'h0F, 2'b01},
    '{16'h1E10, 8'hFF, 8'h00, 5'h00, 8'h00, 5'h04, 2'b01},
    '{16'h0610, 8'h00, 8'h00, 5'h00, 8'hFF, 5'h10, 2'b01},
    '{16'h2A10, 8'h7F, 8'h00, 5'h00, 8'h80, 5'h1A, 2'b01},
    '{16'h2E10, 8'h01, 8'h00, 5'h15, 8'h00, 5'h15, 2'b11},
    '{16'h3E10, 8'h05, 8'h00, 5'h15, 8'h06, 5'h15, 2'b01},
    '{16'h4E10, 8'h05, 8'h00, 5'h15, 8'h04, 5'h15, 2'b11},
    '{16'h4A10, 8'hFF, 8'h00, 5'h15, 8'h00, 5'h15, 2'b01},
    '{16'h3610, 8'h80, 8'h00, 5'h0B, 8'h01, 5'h0B, 2'b01},
    '{16'h3210, 8'h01, 8'h00, 5'h10, 8'h00, 5'h05, 2'b01},
    '{16'h4610, 8'h81, 8'h00, 5'h01, 8'h03, 5'h01, 2'b01},
    '{16'h6210, 8'h33, 8'h33, 5'h1F, 8'h00, 5'h1F, 2'b10},
    '{16'h6410, 8'h40, 8'h30, 5'h1F, 8'h00, 5'h1F, 2'b10},
    '{16'h6010, 8'h40, 8'h30, 5'h1F, 8'h00, 5'h1F, 2'b00},
    '{16'h0210, 8'h10, 8'h10, 5'h1F, 8'h00, 5'h1F, 2'b00}};
  logic [15:0] ai [3] = '{16'h2690, 16'h2610, 16'h2790};
  logic [11:0] ae [3] = '{12'hF90, 12'h010, 12'h590};
  bod_decoder dut (.*);
  // free-running clock
  always #5 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge ref_clk);
      ta = s_axi_awready === 1'b1;
      tw = s_axi_wready === 1'b1;
      tb = s_axi_bvalid === 1'b1;
      rr = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) begin
      num_errors++;
      end_sim();
    end
  endtask
  // bus read into rv and rr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge ref_clk);
      ta = s_axi_arready === 1'b1;
      tr = s_axi_rvalid === 1'b1;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) begin
      num_errors++;
      end_sim();
    end
  endtask
  // load operands and run one instruction word
  task automatic ex(input logic [15:0] i, input logic [7:0] f, a,
                    input logic [4:0] fl);
    wr(REG_ACC, 32'(a));
    wr(REG_FILE_IN, 32'(f));
    wr(REG_FLAGS, 32'(fl));
    wr(REG_INSTR, 32'(i));
    wr(REG_CTRL, 32'h1);
  endtask
  // main sequence: reset and unmapped-access checks, table, then hand-written cases
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_ACC);
    chk(rv, 32'h0);
    rd(8'h3C);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(8'h41, 32'h1);
    chk(32'(rr), 32'(RESP_SLVERR));
    foreach (rows[i]) begin
      ex(rows[i].ins, rows[i].f, rows[i].a, rows[i].fl);
      rd(REG_RESULT);
      chk(32'(rv[12:9]), {29'h1, rows[i].sc[1] ? 2'd2 : 2'd1, rows[i].sc[1]});
      if (rows[i].sc[0]) chk(32'(rv[7:0]), 32'(rows[i].res));
      rd(REG_FLAGS);
      chk(rv, 32'(rows[i].efl));
    end
    rd(REG_PROD);
    chk(rv, 32'h100);
    ex(16'h2410, 8'h01, 8'h02, 5'h00);
    rd(REG_ACC);
    chk(rv, 32'h3);
    wr(REG_BANK, 32'h5);
    for (int i = 0; i < 3; i++) begin
      ex(ai[i], 8'h00, 8'h00, 5'h00);
      rd(REG_ADDR);
      chk(32'(rv[11:0]), 32'(ae[i]));
    end
    ex(16'hC123, 8'h00, 8'h00, 5'h1F);
    rd(REG_RESULT);
    chk(32'(rv[14:10]), 32'h0E);
    ex(16'hF456, 8'h00, 8'h00, 5'h1F);
    rd(REG_MOVE);
    chk(rv, 32'h00456123);
    ex(16'hF456, 8'h00, 8'h00, 5'h1F);
    rd(REG_RESULT);
    chk(32'(rv[14:12]), 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(REG_PROGRAM_TABLE_POINTER, 32'h10);
      ex(16'h0008 | 16'(m), 8'h00, 8'h00, 5'h00);
      rd(REG_TBLUSE);
      chk(rv, 32'h10 + 32'(m == 3));
      rd(REG_PROGRAM_TABLE_POINTER);
      chk(rv, 32'h10 + 32'(m[0]) - 32'(m == 2));
    end
    ex(16'hD7FF, 8'h00, 8'h00, 5'h00);
    rd(REG_DISP);
    chk(rv, 32'h801FFFFF);
    ex(16'h5010, 8'h00, 8'h00, 5'h00);
    rd(REG_RESULT);
    chk(32'(rv[12]), 32'h0);
    ex(16'hED12, 8'h00, 8'h77, 5'h15);
    rd(REG_SHADOW);
    chk(rv, 32'hB577);
    ex(16'hF345, 8'h00, 8'h00, 5'h00);
    ex(16'h0013, 8'h00, 8'h00, 5'h00);
    rd(REG_ACC);
    chk(rv, 32'h77);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_ACC);
    chk(rv, 32'h0);
    end_sim();
  end
endmodule
bind bod_decoder bod_decoder_props u_props (.*);
`default_nettype wire
